// file: core/mcr_defs.vh
`ifndef MCR_DEFS_VH
`define MCR_DEFS_VH
// ********************************
// Register offsets
// ********************************
`define MCR_ADDR_PORT_A      8'h80
`define MCR_ADDR_STACK       8'h81
`define MCR_ADDR_PTR0_LOW    8'h82
`define MCR_ADDR_PTR0_HIGH   8'h83
`define MCR_ADDR_PTR1_LOW    8'h84
`define MCR_ADDR_PTR1_HIGH   8'h85
`define MCR_ADDR_POWER       8'h87
`define MCR_ADDR_STRETCH     8'h8E
`define MCR_ADDR_PORT_B      8'h90
`define MCR_ADDR_PORT_C      8'hA0
`define MCR_ADDR_PORT_D      8'hB0
// ********************************
// Reset values
// ********************************
`define MCR_RST_STACK        8'h07
`define MCR_RST_PTR          8'h00
`define MCR_RST_COUNTER      16'h0000
`define MCR_RST_POWER        8'h00
`define MCR_RST_STRETCH      3'h1
`define MCR_RST_PORT         8'hFF
// ********************************
// Field positions
// ********************************
`define MCR_PWR_LIGHT_BIT    0
`define MCR_PWR_DEEP_BIT     1
`define MCR_PWR_BAUD_BIT     7
`define MCR_PWR_MASK         8'h83
`define MCR_STRETCH_MASK     8'h07
// ********************************
// Access timing (MPU clock cycles)
// ********************************
`define MCR_RD_ADDR_EXTRA    3'h1
`define MCR_WR_ADDR_EXTRA    3'h2
`endif

// file: core/mcr_port_pins.v
`timescale 1ns/1ps
// ********************************
// Four pins of one port latch with input synchroniser
// ********************************
module mcr_port_pins (
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  // Latch and global enable
  input  wire [7:0] latch,
  input  wire       enable,
  // Pins
  input  wire [3:0] pin_in,
  output reg  [3:0] pin_out,
  output reg  [3:0] pin_oe,
  // Synchronised pin level
  output reg  [3:0] level
);
  reg [3:0] sync1;
  reg [3:0] sync2;
  reg [3:0] sync3;

  always @(posedge clk) begin
    if (rst) begin
      sync1   <= 4'h0;
      sync2   <= 4'h0;
      sync3   <= 4'h0;
      level   <= 4'h0;
      pin_out <= 4'h0;
      pin_oe  <= 4'h0;
    end else begin
      sync1   <= pin_in;
      sync2   <= sync1;
      sync3   <= sync2;
      // Level moves only when second and third stages agree
      level   <= (sync2 & sync3) | (level & (sync2 | sync3));
      pin_oe  <= latch[7:4] & {4{enable}};  // RULE5 RULE8
      pin_out <= latch[3:0];  // RULE6
    end
  end
endmodule

// file: core/mcr_stretch_timer.v
`timescale 1ns/1ps
`include "mcr_defs.vh"
// ********************************
// External data move strobe timer
// ********************************
module mcr_stretch_timer (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Request
  input  wire        start,
  input  wire        write,
  input  wire [2:0]  stretch,
  // Strobes
  output reg         addr_phase,
  output reg         rd_strobe,
  output reg         wr_strobe,
  output reg         busy,
  output reg         done
);
  reg [3:0] count;
  reg [3:0] wr_len;
  reg       is_write;

  always @(posedge clk) begin
    if (rst) begin
      count      <= 4'h0;
      wr_len     <= 4'h0;
      is_write   <= 1'b0;
      addr_phase <= 1'b0;
      rd_strobe  <= 1'b0;
      wr_strobe  <= 1'b0;
      busy       <= 1'b0;
      done       <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy       <= 1'b1;
        is_write   <= write;
        addr_phase <= 1'b1;
        rd_strobe  <= !write;
        wr_strobe  <= write;
        // Read: s+1 cycles; write: s+2 address, max(s,1) strobe
        count <= write ? ({1'b0, stretch} + {1'b0, `MCR_WR_ADDR_EXTRA}) - 4'h1
                       : ({1'b0, stretch} + {1'b0, `MCR_RD_ADDR_EXTRA}) - 4'h1;  // RULE10 RULE11
        wr_len <= (stretch == 3'h0) ? 4'h1 : {1'b0, stretch};  // RULE11
      end else if (busy) begin
        if (count == 4'h0) begin
          busy       <= 1'b0;
          addr_phase <= 1'b0;
          rd_strobe  <= 1'b0;
          wr_strobe  <= 1'b0;
          done       <= 1'b1;
        end else begin
          count <= count - 4'h1;
          if (is_write && wr_len <= 4'h1)
            wr_strobe <= 1'b0;
          if (is_write && wr_len != 4'h0)
            wr_len <= wr_len - 4'h1;
        end
      end
    end
  end
endmodule

// file: core/mcr_core_regs.v
`timescale 1ns/1ps
`include "mcr_defs.vh"
// Overview of operation
// RULE1: Stack pointer resets 07, pre-increments on push
// RULE2: Two 16-bit data pointers, byte-writable halves
// RULE3: Instruction counter resets 0000, advances per fetch
// RULE4: Port latch: upper nibble direction, lower value
// RULE5: Direction bit 1 means output
// RULE6: Value bit drives pin high or low
// RULE7: Value read returns actual pin level
// RULE8: Pins inputs until port enable set
// RULE9: 3-bit stretch field resets to one
// RULE10: Read address and strobe last s+1
// RULE11: Write address s+2, strobe max(s,1)
// RULE12: Firmware should set stretch to zero
// RULE13: Light halt bit stops execution only
// RULE14: Any interrupt ends light halt
// RULE15: Deep halt bit stops core and peripherals
// RULE16: Deep halt ends on reset or external interrupt
// RULE17: Bit 7 baud doubling, bits 6..2 unused
// RULE18: Power 00, stretch 01, ports FF at reset
// RULE19: Stretch affects only external data moves
// RULE20: Unused power bits read zero
module mcr_core_regs (
  // Clock and reset
  input  wire        CLOCK,
  input  wire        RESET,
  // Special register access
  input  wire [7:0]  SFR_ADDR,
  input  wire        SFR_WR,
  input  wire        SFR_RD,
  input  wire [7:0]  SFR_WDATA,
  output reg  [7:0]  SFR_RDATA,
  output reg         SFR_HIT,
  // Core sequencing events
  input  wire        FETCH_STEP,
  input  wire        COUNTER_LOAD,
  input  wire [15:0] COUNTER_VALUE,
  input  wire        STACK_PUSH,
  input  wire        STACK_POP,
  input  wire        POINTER_SELECT,
  input  wire        POINTER_INC,
  // External data move
  input  wire        XMOVE_START,
  input  wire        XMOVE_WRITE,
  output reg         XMOVE_ADDR_PHASE,
  output reg         XMOVE_RD_STROBE,
  output reg         XMOVE_WR_STROBE,
  output reg         XMOVE_DONE,
  output reg  [15:0] XMOVE_ADDRESS,
  // Pointer and counter views
  output reg  [15:0] INSTRUCTION_COUNTER,
  output reg  [7:0]  STACK_TOP_POINTER,
  output reg  [15:0] FIRST_ADDRESS_POINTER,
  output reg  [15:0] SECOND_ADDRESS_POINTER,
  // Power management
  input  wire        ANY_INTERRUPT,
  input  wire        EXT_INTERRUPT,
  output reg         CORE_HALT,
  output reg         PERIPH_HALT,
  output reg         BAUD_DOUBLE,
  // Shared general pins
  input  wire        PORT_ENABLE,
  input  wire [15:0] PIN_IN,
  output reg  [15:0] PIN_OUT,
  output reg  [15:0] PIN_OE
);
  // ********************************
  // Register state
  // ********************************
  reg  [7:0]  stack_top_pointer;
  reg  [7:0]  first_pointer_low;
  reg  [7:0]  first_pointer_high;
  reg  [7:0]  second_pointer_low;
  reg  [7:0]  second_pointer_high;
  reg  [15:0] instruction_counter;
  reg  [7:0]  power_control_register;
  reg  [2:0]  stretch_select;
  reg  [7:0]  port_latch_a;
  reg  [7:0]  port_latch_b;
  reg  [7:0]  port_latch_c;
  reg  [7:0]  port_latch_d;
  reg  [7:0]  next_rdata;
  reg         next_hit;
  wire [15:0] pin_level;
  wire [15:0] pin_out_w;
  wire [15:0] pin_oe_w;
  wire        t_addr;
  wire        t_rd;
  wire        t_wr;
  wire        t_done;
  wire [15:0] sel_ptr;
  wire [15:0] sel_ptr_inc;
  wire        wr_en;

  // Halted core takes no register writes or sequencing steps
  assign wr_en       = SFR_WR && !CORE_HALT;
  assign sel_ptr     = POINTER_SELECT ? {second_pointer_high, second_pointer_low}
                                      : {first_pointer_high, first_pointer_low};
  assign sel_ptr_inc = sel_ptr + 16'h0001;

  function hit_at;
    input [7:0] a;
    input [7:0] b;
    begin
      hit_at = (a == b);
    end
  endfunction

  // ********************************
  // Pin slices and stretch timer
  // ********************************
  mcr_port_pins u_pins_a (
    .clk     (CLOCK),
    .rst     (RESET),
    .latch   (port_latch_a),
    .enable  (PORT_ENABLE),
    .pin_in  (PIN_IN[3:0]),
    .pin_out (pin_out_w[3:0]),
    .pin_oe  (pin_oe_w[3:0]),
    .level   (pin_level[3:0])
  );
  mcr_port_pins u_pins_b (
    .clk     (CLOCK),
    .rst     (RESET),
    .latch   (port_latch_b),
    .enable  (PORT_ENABLE),
    .pin_in  (PIN_IN[7:4]),
    .pin_out (pin_out_w[7:4]),
    .pin_oe  (pin_oe_w[7:4]),
    .level   (pin_level[7:4])
  );
  mcr_port_pins u_pins_c (
    .clk     (CLOCK),
    .rst     (RESET),
    .latch   (port_latch_c),
    .enable  (PORT_ENABLE),
    .pin_in  (PIN_IN[11:8]),
    .pin_out (pin_out_w[11:8]),
    .pin_oe  (pin_oe_w[11:8]),
    .level   (pin_level[11:8])
  );
  mcr_port_pins u_pins_d (
    .clk     (CLOCK),
    .rst     (RESET),
    .latch   (port_latch_d),
    .enable  (PORT_ENABLE),
    .pin_in  (PIN_IN[15:12]),
    .pin_out (pin_out_w[15:12]),
    .pin_oe  (pin_oe_w[15:12]),
    .level   (pin_level[15:12])
  );

  // Only external data moves reach the stretch timer
  mcr_stretch_timer u_timer (  // RULE19
    .clk        (CLOCK),
    .rst        (RESET),
    .start      (XMOVE_START && !CORE_HALT),
    .write      (XMOVE_WRITE),
    .stretch    (stretch_select),  // RULE9
    .addr_phase (t_addr),
    .rd_strobe  (t_rd),
    .wr_strobe  (t_wr),
    .busy       (),
    .done       (t_done)
  );

  // ********************************
  // Register writes and sequencing
  // ********************************
  always @(posedge CLOCK) begin
    if (RESET) begin
      stack_top_pointer      <= `MCR_RST_STACK;  // RULE1
      first_pointer_low      <= `MCR_RST_PTR;
      first_pointer_high     <= `MCR_RST_PTR;
      second_pointer_low     <= `MCR_RST_PTR;
      second_pointer_high    <= `MCR_RST_PTR;
      instruction_counter    <= `MCR_RST_COUNTER;  // RULE3
      power_control_register <= `MCR_RST_POWER;  // RULE18
      stretch_select         <= `MCR_RST_STRETCH;  // RULE18
      port_latch_a           <= `MCR_RST_PORT;  // RULE18
      port_latch_b           <= `MCR_RST_PORT;
      port_latch_c           <= `MCR_RST_PORT;
      port_latch_d           <= `MCR_RST_PORT;
    end else begin
      if (!CORE_HALT) begin
        if (COUNTER_LOAD)
          instruction_counter <= COUNTER_VALUE;
        else if (FETCH_STEP)
          instruction_counter <= instruction_counter + 16'h0001;  // RULE3
        if (STACK_PUSH)
          stack_top_pointer <= stack_top_pointer + 8'h01;  // RULE1
        else if (STACK_POP)
          stack_top_pointer <= stack_top_pointer - 8'h01;
        if (POINTER_INC && !POINTER_SELECT) begin
          first_pointer_low  <= sel_ptr_inc[7:0];
          first_pointer_high <= sel_ptr_inc[15:8];
        end
        if (POINTER_INC && POINTER_SELECT) begin
          second_pointer_low  <= sel_ptr_inc[7:0];
          second_pointer_high <= sel_ptr_inc[15:8];
        end
      end
      if (wr_en) begin
        if (hit_at(SFR_ADDR, `MCR_ADDR_STACK))
          stack_top_pointer <= SFR_WDATA;
        else if (hit_at(SFR_ADDR, `MCR_ADDR_PTR0_LOW))
          first_pointer_low <= SFR_WDATA;  // RULE2
        else if (hit_at(SFR_ADDR, `MCR_ADDR_PTR0_HIGH))
          first_pointer_high <= SFR_WDATA;  // RULE2
        else if (hit_at(SFR_ADDR, `MCR_ADDR_PTR1_LOW))
          second_pointer_low <= SFR_WDATA;  // RULE2
        else if (hit_at(SFR_ADDR, `MCR_ADDR_PTR1_HIGH))
          second_pointer_high <= SFR_WDATA;  // RULE2
        else if (hit_at(SFR_ADDR, `MCR_ADDR_POWER))
          power_control_register <= SFR_WDATA & `MCR_PWR_MASK;  // RULE13 RULE15 RULE17 RULE20
        else if (hit_at(SFR_ADDR, `MCR_ADDR_STRETCH))
          stretch_select <= SFR_WDATA[2:0];  // RULE9 RULE12
        else if (hit_at(SFR_ADDR, `MCR_ADDR_PORT_A))
          port_latch_a <= SFR_WDATA;  // RULE4
        else if (hit_at(SFR_ADDR, `MCR_ADDR_PORT_B))
          port_latch_b <= SFR_WDATA;  // RULE4
        else if (hit_at(SFR_ADDR, `MCR_ADDR_PORT_C))
          port_latch_c <= SFR_WDATA;  // RULE4
        else if (hit_at(SFR_ADDR, `MCR_ADDR_PORT_D))
          port_latch_d <= SFR_WDATA;  // RULE4
      end
      // Wake wins over a same-cycle write; core resumes after the halting write
      if (power_control_register[`MCR_PWR_LIGHT_BIT] && ANY_INTERRUPT)
        power_control_register[`MCR_PWR_LIGHT_BIT] <= 1'b0;  // RULE14
      if (power_control_register[`MCR_PWR_DEEP_BIT] && EXT_INTERRUPT)
        power_control_register[`MCR_PWR_DEEP_BIT] <= 1'b0;  // RULE16
    end
  end

  // ********************************
  // Read decode
  // ********************************
  always @* begin
    next_rdata = 8'h00;
    next_hit   = 1'b1;
    if (hit_at(SFR_ADDR, `MCR_ADDR_STACK))
      next_rdata = stack_top_pointer;
    else if (hit_at(SFR_ADDR, `MCR_ADDR_PTR0_LOW))
      next_rdata = first_pointer_low;
    else if (hit_at(SFR_ADDR, `MCR_ADDR_PTR0_HIGH))
      next_rdata = first_pointer_high;
    else if (hit_at(SFR_ADDR, `MCR_ADDR_PTR1_LOW))
      next_rdata = second_pointer_low;
    else if (hit_at(SFR_ADDR, `MCR_ADDR_PTR1_HIGH))
      next_rdata = second_pointer_high;
    else if (hit_at(SFR_ADDR, `MCR_ADDR_POWER))
      next_rdata = power_control_register & `MCR_PWR_MASK;  // RULE20
    else if (hit_at(SFR_ADDR, `MCR_ADDR_STRETCH))
      next_rdata = {5'h00, stretch_select};
    else if (hit_at(SFR_ADDR, `MCR_ADDR_PORT_A))
      next_rdata = {port_latch_a[7:4], pin_level[3:0]};  // RULE7
    else if (hit_at(SFR_ADDR, `MCR_ADDR_PORT_B))
      next_rdata = {port_latch_b[7:4], pin_level[7:4]};  // RULE7
    else if (hit_at(SFR_ADDR, `MCR_ADDR_PORT_C))
      next_rdata = {port_latch_c[7:4], pin_level[11:8]};  // RULE7
    else if (hit_at(SFR_ADDR, `MCR_ADDR_PORT_D))
      next_rdata = {port_latch_d[7:4], pin_level[15:12]};  // RULE7
    else
      next_hit = 1'b0;
  end

  // ********************************
  // Registered outputs
  // ********************************
  always @(posedge CLOCK) begin
    if (RESET) begin
      SFR_RDATA              <= 8'h00;
      SFR_HIT                <= 1'b0;
      XMOVE_ADDR_PHASE       <= 1'b0;
      XMOVE_RD_STROBE        <= 1'b0;
      XMOVE_WR_STROBE        <= 1'b0;
      XMOVE_DONE             <= 1'b0;
      XMOVE_ADDRESS          <= 16'h0000;
      INSTRUCTION_COUNTER    <= 16'h0000;
      STACK_TOP_POINTER      <= 8'h00;
      FIRST_ADDRESS_POINTER  <= 16'h0000;
      SECOND_ADDRESS_POINTER <= 16'h0000;
      CORE_HALT              <= 1'b0;
      PERIPH_HALT            <= 1'b0;
      BAUD_DOUBLE            <= 1'b0;
      PIN_OUT                <= 16'h0000;
      PIN_OE                 <= 16'h0000;  // RULE8
    end else begin
      SFR_RDATA              <= SFR_RD ? next_rdata : 8'h00;
      SFR_HIT                <= (SFR_RD || SFR_WR) && next_hit;
      XMOVE_ADDR_PHASE       <= t_addr;  // RULE10 RULE11
      XMOVE_RD_STROBE        <= t_rd;
      XMOVE_WR_STROBE        <= t_wr;
      XMOVE_DONE             <= t_done;
      // A start refused by the halted core must not move the address
      if (XMOVE_START && !t_addr && !CORE_HALT)
        XMOVE_ADDRESS <= sel_ptr;  // RULE2
      INSTRUCTION_COUNTER    <= instruction_counter;
      STACK_TOP_POINTER      <= stack_top_pointer;
      FIRST_ADDRESS_POINTER  <= {first_pointer_high, first_pointer_low};
      SECOND_ADDRESS_POINTER <= {second_pointer_high, second_pointer_low};
      // Halt drops on the same edge that a wake clears its bit
      CORE_HALT   <= power_control_register[`MCR_PWR_LIGHT_BIT] && !ANY_INTERRUPT ||
                     power_control_register[`MCR_PWR_DEEP_BIT] && !EXT_INTERRUPT;  // RULE13 RULE15
      PERIPH_HALT <= power_control_register[`MCR_PWR_DEEP_BIT] && !EXT_INTERRUPT;  // RULE15
      BAUD_DOUBLE <= power_control_register[`MCR_PWR_BAUD_BIT];  // RULE17
      PIN_OUT     <= pin_out_w;  // RULE6
      PIN_OE      <= pin_oe_w;  // RULE5
    end
  end
endmodule

// file: tb/mcr_core_regs_monitor.sv
`timescale 1ns/1ps
`include "mcr_defs.vh"
// ********************************
// Port checker for the core registers
// ********************************
module mcr_core_regs_monitor (
  // Clock and reset
  input wire        CLOCK,
  input wire        RESET,
  // Register port
  input wire [7:0]  SFR_ADDR,
  input wire        SFR_WR,
  input wire        SFR_RD,
  input wire [7:0]  SFR_WDATA,
  input wire [7:0]  SFR_RDATA,
  input wire        SFR_HIT,
  // Sequencing
  input wire        FETCH_STEP,
  input wire        COUNTER_LOAD,
  input wire        STACK_PUSH,
  input wire [15:0] INSTRUCTION_COUNTER,
  input wire [7:0]  STACK_TOP_POINTER,
  // External move
  input wire        XMOVE_ADDR_PHASE,
  input wire        XMOVE_RD_STROBE,
  input wire        XMOVE_WR_STROBE,
  input wire        XMOVE_DONE,
  // Power and pins
  input wire        ANY_INTERRUPT,
  input wire        EXT_INTERRUPT,
  input wire        CORE_HALT,
  input wire        PERIPH_HALT,
  input wire        PORT_ENABLE,
  input wire [15:0] PIN_OUT,
  input wire [15:0] PIN_OE
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);
  reg [2:0] str;
  reg [3:0] alen;
  reg [3:0] wlen;
  // Stretch shadow; assumes no stretch write near a halt change
  always @(posedge CLOCK) begin
    if (RESET) str <= `MCR_RST_STRETCH;
    else if (SFR_WR && !CORE_HALT && SFR_ADDR == `MCR_ADDR_STRETCH) str <= SFR_WDATA[2:0];
    alen <= XMOVE_ADDR_PHASE ? alen + 4'h1 : 4'h0;
    wlen <= XMOVE_WR_STROBE ? wlen + 4'h1 : 4'h0;
  end
  sequence fetch_taken;
    !CORE_HALT && FETCH_STEP && !COUNTER_LOAD ##1 1'b1;
  endsequence
  sequence port_write;
    SFR_WR && !CORE_HALT && SFR_ADDR == `MCR_ADDR_PORT_A && PORT_ENABLE ##1
    PORT_ENABLE && !(SFR_WR && SFR_ADDR == `MCR_ADDR_PORT_A);
  endsequence
  sequence light_request;
    SFR_WR && !CORE_HALT && SFR_ADDR == `MCR_ADDR_POWER && SFR_WDATA[1:0] == 2'h1 && !ANY_INTERRUPT ##1 !ANY_INTERRUPT;
  endsequence
  stack_pre_inc_a: assert property (STACK_PUSH && !(SFR_WR && SFR_ADDR == `MCR_ADDR_STACK) |-> ##2
    STACK_TOP_POINTER == $past(STACK_TOP_POINTER) + 8'h01) else $error("stack pointer missed a push");
  counter_step_a: assert property (fetch_taken |=>
    INSTRUCTION_COUNTER == $past(INSTRUCTION_COUNTER) + 16'h0001) else $error("counter missed a fetch");
  pins_blocked_a: assert property ((!PORT_ENABLE)[*3] |-> PIN_OE == 16'h0000)
    else $error("pins driven while ports disabled");
  port_drive_a: assert property (port_write |=> ##1 PIN_OE[3:0] == $past(SFR_WDATA[7:4], 3) &&
    PIN_OUT[3:0] == $past(SFR_WDATA[3:0], 3)) else $error("port pins do not follow latch");
  read_width_a: assert property ($fell(XMOVE_ADDR_PHASE) && $past(XMOVE_RD_STROBE) |->
    XMOVE_DONE && !XMOVE_RD_STROBE && alen == {1'b0, str} + 4'h1) else $error("read phase length wrong");
  write_width_a: assert property ($fell(XMOVE_ADDR_PHASE) && !$past(XMOVE_RD_STROBE) |->
    XMOVE_DONE && alen == {1'b0, str} + 4'h2) else $error("write phase length wrong");
  strobe_width_a: assert property ($fell(XMOVE_WR_STROBE) |-> XMOVE_ADDR_PHASE &&
    wlen == ((str == 3'h0) ? 4'h1 : {1'b0, str})) else $error("write strobe length wrong");
  light_entry_a: assert property (light_request |=> CORE_HALT && !PERIPH_HALT)
    else $error("light halt not entered");
  light_wake_a: assert property (CORE_HALT && !PERIPH_HALT && ANY_INTERRUPT |-> ##[1:2] !CORE_HALT)
    else $error("interrupt did not end light halt");
  deep_hold_a: assert property (PERIPH_HALT && !EXT_INTERRUPT && !$past(EXT_INTERRUPT) |=> PERIPH_HALT)
    else $error("deep halt left without wake event");
  power_read_a: assert property (SFR_RD && SFR_ADDR == `MCR_ADDR_POWER |=>
    SFR_HIT && SFR_RDATA[6:2] == 5'h00) else $error("unused power bits not zero");
endmodule

bind mcr_core_regs mcr_core_regs_monitor u_monitor (.CLOCK, .RESET, .SFR_ADDR, .SFR_WR, .SFR_RD, .SFR_WDATA,
  .SFR_RDATA, .SFR_HIT, .FETCH_STEP, .COUNTER_LOAD, .STACK_PUSH, .INSTRUCTION_COUNTER, .STACK_TOP_POINTER,
  .XMOVE_ADDR_PHASE, .XMOVE_RD_STROBE, .XMOVE_WR_STROBE, .XMOVE_DONE, .ANY_INTERRUPT, .EXT_INTERRUPT,
  .CORE_HALT, .PERIPH_HALT, .PORT_ENABLE, .PIN_OUT, .PIN_OE);

// file: tb/mcr_core_regs_bench.sv
`timescale 1ns/1ps
`include "mcr_defs.vh"
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin fails++; \
  $display("[FAIL] %s expected %h seen %h", n, e, s); end end
module mcr_core_regs_bench;
  logic        CLOCK, RESET, SFR_WR, SFR_RD, FETCH_STEP, COUNTER_LOAD, STACK_PUSH, STACK_POP;
  logic        POINTER_SELECT, POINTER_INC, XMOVE_START, XMOVE_WRITE, ANY_INTERRUPT, EXT_INTERRUPT, PORT_ENABLE;
  logic [7:0]  SFR_ADDR, SFR_WDATA;
  logic [15:0] COUNTER_VALUE, PIN_IN;
  wire  [7:0]  SFR_RDATA, STACK_TOP_POINTER;
  wire         SFR_HIT, XMOVE_ADDR_PHASE, XMOVE_RD_STROBE, XMOVE_WR_STROBE, XMOVE_DONE;
  wire         CORE_HALT, PERIPH_HALT, BAUD_DOUBLE;
  wire  [15:0] XMOVE_ADDRESS, INSTRUCTION_COUNTER, FIRST_ADDRESS_POINTER, SECOND_ADDRESS_POINTER, PIN_OUT, PIN_OE;
  int          fails, cmp_count, n_a, n_r, n_w;
  logic [31:0] seed;
  logic [8:0]  notes[$];
  logic        rd_seen;
  logic [7:0]  pv [4];
  logic [15:0] fp, sp, pcv, mv;
  localparam logic [7:0] PA [4] = '{`MCR_ADDR_PORT_A, `MCR_ADDR_PORT_B, `MCR_ADDR_PORT_C, `MCR_ADDR_PORT_D};

  mcr_core_regs DUT (.CLOCK, .RESET, .SFR_ADDR, .SFR_WR, .SFR_RD, .SFR_WDATA, .SFR_RDATA, .SFR_HIT, .FETCH_STEP,
    .COUNTER_LOAD, .COUNTER_VALUE, .STACK_PUSH, .STACK_POP, .POINTER_SELECT, .POINTER_INC, .XMOVE_START,
    .XMOVE_WRITE, .XMOVE_ADDR_PHASE, .XMOVE_RD_STROBE, .XMOVE_WR_STROBE, .XMOVE_DONE, .XMOVE_ADDRESS,
    .INSTRUCTION_COUNTER, .STACK_TOP_POINTER, .FIRST_ADDRESS_POINTER, .SECOND_ADDRESS_POINTER, .ANY_INTERRUPT,
    .EXT_INTERRUPT, .CORE_HALT, .PERIPH_HALT, .BAUD_DOUBLE, .PORT_ENABLE, .PIN_IN, .PIN_OUT, .PIN_OE);

  initial begin
    CLOCK = 1'b0;
    forever #20 CLOCK = ~CLOCK;
  end

  // ********************************
  // Helpers
  // ********************************
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    SFR_ADDR <= a;
    SFR_WDATA <= d;
    SFR_WR <= 1'b1;
    @(posedge CLOCK);
    SFR_WR <= 1'b0;
  endtask
  // Expected word is {hit, data}, checked by the watcher
  task automatic rd(input logic [7:0] a, input logic [8:0] e);
    @(posedge CLOCK);
    SFR_ADDR <= a;
    SFR_RD <= 1'b1;
    notes.push_back(e);
    @(posedge CLOCK);
    SFR_RD <= 1'b0;
  endtask
  task automatic do_reset;
    RESET <= 1'b1;
    tick(16);
    RESET <= 1'b0;
    tick(2);
  endtask
  task automatic xmove(input logic w, input logic [2:0] s);
    n_a = 0;
    n_r = 0;
    n_w = 0;
    seed = xs(seed);
    @(posedge CLOCK);
    XMOVE_START <= 1'b1;
    XMOVE_WRITE <= w;
    POINTER_SELECT <= seed[0];
    @(posedge CLOCK);
    XMOVE_START <= 1'b0;
    for (int k = 0; k < 30 && XMOVE_DONE !== 1'b1; k++) begin
      @(negedge CLOCK);
      n_a += XMOVE_ADDR_PHASE;
      n_r += XMOVE_RD_STROBE;
      n_w += XMOVE_WR_STROBE;
      if (XMOVE_ADDR_PHASE === 1'b1) mv = XMOVE_ADDRESS;
    end
    `CHK("move done", 1'b1, XMOVE_DONE)
    `CHK("address width", s + 1 + w, n_a)
    `CHK("read width", w ? 0 : s + 1, n_r)
    `CHK("write width", w ? ((s == 0) ? 1 : int'(s)) : 0, n_w)
    `CHK("move address", seed[0] ? sp : fp, mv)
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge CLOCK) begin
    rd_seen <= SFR_RD;
    if (rd_seen === 1'b1 && notes.size() > 0) begin
      `CHK("register read", notes[0], {SFR_HIT, SFR_RDATA})
      void'(notes.pop_front());
    end
  end

  initial begin
    tick(5000);
    fails++;
    stop_test;
  end

  // ********************************
  // Scenarios
  // ********************************
  initial begin
    {SFR_WR, SFR_RD, FETCH_STEP, COUNTER_LOAD, STACK_PUSH, STACK_POP, POINTER_SELECT, POINTER_INC} = 8'h00;
    {XMOVE_START, XMOVE_WRITE, ANY_INTERRUPT, EXT_INTERRUPT, PORT_ENABLE} = 5'h00;
    {SFR_ADDR, SFR_WDATA, COUNTER_VALUE, PIN_IN} = 48'h0;
    RESET = 1'b1;
    seed = 32'h8E852F0E;
    fails = 0;
    cmp_count = 0;
    do_reset;
    rd(`MCR_ADDR_STACK, 9'h107);
    for (int i = 2; i < 6; i++) rd(8'h80 + i[7:0], 9'h100);
    rd(`MCR_ADDR_POWER, 9'h100);
    rd(`MCR_ADDR_STRETCH, 9'h101);
    rd(8'h86, 9'h000);
    for (int i = 0; i < 4; i++) rd(PA[i], 9'h1F0);
    `CHK("counter reset", 16'h0000, INSTRUCTION_COUNTER)
    $display("reset values done");
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      pv[i] = (i == 2) ? 8'hFF : seed[7:0];
      wr(8'h82 + i[7:0], pv[i]);
      rd(8'h82 + i[7:0], {1'b1, pv[i]});
    end
    fp = {pv[1], pv[0]};
    sp = {pv[3] + 8'h01, 8'h00};
    @(posedge CLOCK);
    POINTER_SELECT <= 1'b1;
    POINTER_INC <= 1'b1;
    @(posedge CLOCK);
    POINTER_INC <= 1'b0;
    STACK_PUSH <= 1'b1;
    tick(2);
    STACK_PUSH <= 1'b0;
    STACK_POP <= 1'b1;
    @(posedge CLOCK);
    STACK_POP <= 1'b0;
    tick(3);
    `CHK("first pointer", fp, FIRST_ADDRESS_POINTER)
    `CHK("second pointer", sp, SECOND_ADDRESS_POINTER)
    `CHK("stack view", 8'h08, STACK_TOP_POINTER)
    $display("pointers and stack done");
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      PIN_IN[i*4 +: 4] <= ~seed[3:0];
      wr(PA[i], seed[7:0]);
      tick(3);
      `CHK("blocked drive", 4'h0, PIN_OE[i*4 +: 4])
      PORT_ENABLE <= 1'b1;
      tick(4);
      `CHK("pin direction", seed[7:4], PIN_OE[i*4 +: 4])
      `CHK("pin value", seed[3:0], PIN_OUT[i*4 +: 4])
      rd(PA[i], {1'b1, seed[7:4], ~seed[3:0]});
      // Enabled write: direction and value move together
      wr(PA[i], ~seed[7:0]);
      tick(3);
      `CHK("enabled write", ~seed[7:0], {PIN_OE[i*4 +: 4], PIN_OUT[i*4 +: 4]})
      PORT_ENABLE <= 1'b0;
    end
    $display("ports done");
    for (int s = 0; s < 8; s++) begin
      wr(`MCR_ADDR_STRETCH, s[7:0]);
      rd(`MCR_ADDR_STRETCH, {1'b1, s[7:0]});
      xmove(1'b0, s[2:0]);
      xmove(1'b1, s[2:0]);
    end
    $display("stretch done");
    seed = xs(seed);
    pcv = seed[15:0] + 16'h0005;
    @(posedge CLOCK);
    COUNTER_VALUE <= seed[15:0];
    COUNTER_LOAD <= 1'b1;
    FETCH_STEP <= 1'b1;
    @(posedge CLOCK);
    COUNTER_LOAD <= 1'b0;
    tick(5);
    FETCH_STEP <= 1'b0;
    tick(3);
    `CHK("counter", pcv, INSTRUCTION_COUNTER)
    wr(`MCR_ADDR_STRETCH, 8'h00);
    wr(`MCR_ADDR_POWER, 8'hFC);
    rd(`MCR_ADDR_POWER, 9'h180);
    `CHK("baud double", 1'b1, BAUD_DOUBLE)
    wr(`MCR_ADDR_POWER, 8'h81);
    tick(2);
    `CHK("light halt", 2'b10, {CORE_HALT, PERIPH_HALT})
    FETCH_STEP <= 1'b1;
    wr(`MCR_ADDR_STACK, 8'h55);
    FETCH_STEP <= 1'b0;
    rd(`MCR_ADDR_STACK, 9'h108);
    `CHK("halted counter", pcv, INSTRUCTION_COUNTER)
    ANY_INTERRUPT <= 1'b1;
    @(posedge CLOCK);
    ANY_INTERRUPT <= 1'b0;
    tick(3);
    `CHK("light wake", 1'b0, CORE_HALT)
    rd(`MCR_ADDR_POWER, 9'h180);
    FETCH_STEP <= 1'b1;
    @(posedge CLOCK);
    FETCH_STEP <= 1'b0;
    tick(3);
    `CHK("resumed counter", pcv + 16'h0001, INSTRUCTION_COUNTER)
    wr(`MCR_ADDR_POWER, 8'h02);
    tick(3);
    `CHK("deep halt", 2'b11, {CORE_HALT, PERIPH_HALT})
    ANY_INTERRUPT <= 1'b1;
    tick(2);
    ANY_INTERRUPT <= 1'b0;
    tick(4);
    `CHK("deep kept", 1'b1, PERIPH_HALT)
    EXT_INTERRUPT <= 1'b1;
    tick(3);
    EXT_INTERRUPT <= 1'b0;
    tick(2);
    `CHK("deep wake", 1'b0, PERIPH_HALT)
    wr(`MCR_ADDR_POWER, 8'h02);
    tick(3);
    do_reset;
    `CHK("reset wake", 1'b0, PERIPH_HALT)
    rd(`MCR_ADDR_STACK, 9'h107);
    rd(`MCR_ADDR_STRETCH, 9'h101);
    tick(4);
    $display("power done");
    stop_test;
  end
endmodule
